// [core/supsup_ctrl.sv]
// control and status of the high-side supply supervisor
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "supsup_defines.svh"
// What this block does
// (R1) Enable switches supervisor; off means no events
// (R2) Mode selects supervisor reset or monitor
// (R3) Not forced: low supply drops to linear
// (R4) Forced: regulator stays in switching mode
// (R5) Trip code is three low bits
// (R6) Trip code reads back as written
// (R7) Performance setting chosen and read back
// (R8) Pin option drives flag onto alarm pin
// (R9) Polarity picks low or high while set
// (R10) Pin option off: pin ignores flag
// (R11) Interrupt enable gates flag onto request
// (R12) Status read returns the event flag
// (R13) Software clear drops flag and request
// (R14) Handler clears flag; no auto clear
// (R15) Flag sets on trip, sticky until cleared
// (R16) Monitor mode sets flag, no reset
module supsup_ctrl (
  input wire logic i_core_clk, // clock, 10 MHz
  input wire logic i_reset, // sync reset, high
  input wire logic [7:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after strobe
  input wire logic i_below_trip, // comparator: supply below trip
  input wire logic i_below_dcdc_min, // supply below switching minimum
  output logic o_sup_enable, // comparator power on
  output logic [2:0] o_trip_code, // trip level to comparator
  output logic o_full_perf, // full performance mode
  output logic o_reset_req, // device reset request
  output logic o_regulator_linear, // regulator in linear mode
  output logic o_supply_alarm_out_pin, // alarm pin
  output logic o_irq // interrupt request, level
);
  supsup_pkg::supsup_state_s state_reg;
  supsup_pkg::supsup_state_s state_next;
  logic below_q;
  logic wr_ctrl;
  logic wr_trip;
  logic wr_stat;
  logic wr_mask;
  logic clr_flag;

  // ====================================================
  // comparator qualification
  supsup_qualify u_qual (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_enable(state_reg.en),
    .i_raw(i_below_trip),
    .o_level(below_q)
  );

  // ====================================================
  // register decode
  assign wr_ctrl = i_wr && (i_addr == `SUPSUP_OFF_CTRL);
  assign wr_trip = i_wr && (i_addr == `SUPSUP_OFF_TRIP);
  assign wr_stat = i_wr && (i_addr == `SUPSUP_OFF_STAT);
  assign wr_mask = i_wr && (i_addr == `SUPSUP_OFF_MASK);
  // write-one-to-clear; no clear on acknowledge
  assign clr_flag = wr_stat && i_wdata[`SUPSUP_STAT_FLAG]; // R13 R14

  // ====================================================
  // next state
  always_comb begin
    state_next = state_reg;
    if (wr_ctrl) begin
      state_next.en = i_wdata[`SUPSUP_CTRL_EN]; // R1
      state_next.mon = i_wdata[`SUPSUP_CTRL_MON]; // R2
      state_next.forced = i_wdata[`SUPSUP_CTRL_FORCED]; // R3 R4
      state_next.full_perf = i_wdata[`SUPSUP_CTRL_FULLPERF]; // R7
      state_next.pin_en = i_wdata[`SUPSUP_CTRL_PINEN]; // R8
      state_next.pin_low = i_wdata[`SUPSUP_CTRL_PINLOW]; // R9
    end
    if (wr_trip) begin
      // only the low three bits of the byte carry the code
      state_next.trip = i_wdata[`SUPSUP_TRIP_MSB:0]; // R5
    end
    if (wr_mask) begin
      state_next.irq_en = i_wdata[`SUPSUP_MASK_IE]; // R11
    end
    // set wins over clear so a trip in the clear cycle survives
    if (clr_flag) begin
      state_next.flag = 1'b0; // R13
    end
    if (state_reg.en && below_q) begin
      state_next.flag = 1'b1; // R15 R1
    end
    // reset only from an enabled supervisor, never a monitor
    state_next.reset_req = state_next.en && !state_next.mon && below_q; // R2 R16 R1
    // fail-safe is suppressed when switching is forced
    state_next.linear = !state_next.forced && i_below_dcdc_min; // R3 R4
    // pin follows the flag only while the option is on
    if (state_next.pin_en) begin
      state_next.pin = state_next.flag ^ state_next.pin_low; // R8 R9
    end else begin
      state_next.pin = 1'b0; // R10
    end
    // read data stand only in the cycle after the strobe
    state_next.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `SUPSUP_OFF_CTRL: begin
          state_next.rdata[`SUPSUP_CTRL_EN] = state_reg.en;
          state_next.rdata[`SUPSUP_CTRL_MON] = state_reg.mon;
          state_next.rdata[`SUPSUP_CTRL_FORCED] = state_reg.forced;
          state_next.rdata[`SUPSUP_CTRL_FULLPERF] = state_reg.full_perf; // R7
          state_next.rdata[`SUPSUP_CTRL_PINEN] = state_reg.pin_en;
          state_next.rdata[`SUPSUP_CTRL_PINLOW] = state_reg.pin_low;
        end
        `SUPSUP_OFF_TRIP: begin
          state_next.rdata[`SUPSUP_TRIP_MSB:0] = state_reg.trip; // R6
        end
        `SUPSUP_OFF_STAT: begin
          state_next.rdata[`SUPSUP_STAT_FLAG] = state_reg.flag; // R12
          state_next.rdata[`SUPSUP_STAT_BELOW] = below_q;
          state_next.rdata[`SUPSUP_STAT_LINEAR] = state_reg.linear;
        end
        `SUPSUP_OFF_MASK: begin
          state_next.rdata[`SUPSUP_MASK_IE] = state_reg.irq_en;
        end
        default: begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ====================================================
  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= '0;
      state_reg.en <= 1'(`SUPSUP_RST_CTRL >> `SUPSUP_CTRL_EN);
      state_reg.trip <= `SUPSUP_RST_TRIP;
      state_reg.irq_en <= `SUPSUP_RST_IE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ====================================================
  // outputs
  assign o_rdata = state_reg.rdata;
  assign o_sup_enable = state_reg.en;
  assign o_trip_code = state_reg.trip;
  assign o_full_perf = state_reg.full_perf;
  assign o_reset_req = state_reg.reset_req;
  assign o_regulator_linear = state_reg.linear;
  assign o_supply_alarm_out_pin = state_reg.pin;
  // request drops with the flag or the interrupt enable, same cycle
  assign o_irq = state_reg.flag && state_reg.irq_en; // R11 R13

  // ====================================================
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  off_no_reset_a: assert property ( // R1
    !o_sup_enable |-> !o_reset_req
  ) else $error("reset request while supervisor off");

  off_no_set_a: assert property ( // R1
    !state_reg.en && !state_reg.flag && !clr_flag ##1 !state_reg.en |-> !state_reg.flag
  ) else $error("flag set while supervisor off");

  sup_reset_a: assert property ( // R2
    state_reg.en && !state_reg.mon && below_q && !i_wr |=> o_reset_req
  ) else $error("supervisor trip gave no reset request");

  mon_no_reset_a: assert property ( // R16
    state_reg.mon |-> !o_reset_req
  ) else $error("monitor mode raised a reset request");

  failsafe_a: assert property ( // R3
    !state_reg.forced && i_below_dcdc_min && !wr_ctrl |=> o_regulator_linear
  ) else $error("fail-safe did not fall back to linear");

  forced_sw_a: assert property ( // R4
    state_reg.forced |-> !o_regulator_linear
  ) else $error("forced switching left switching mode");

  trip_read_a: assert property ( // R6
    wr_trip ##1 (i_rd && i_addr == `SUPSUP_OFF_TRIP && !i_wr)
      |=> o_rdata == {29'h0, $past(i_wdata[2:0], 2)}
  ) else $error("trip code read back wrong");

  perf_read_a: assert property ( // R7
    i_rd && i_addr == `SUPSUP_OFF_CTRL |=> o_rdata[`SUPSUP_CTRL_FULLPERF] == $past(o_full_perf)
  ) else $error("performance setting read back wrong");

  pin_pol_a: assert property ( // R8
    state_reg.pin_en |-> o_supply_alarm_out_pin == (state_reg.flag ^ state_reg.pin_low)
  ) else $error("alarm pin does not follow flag and polarity");

  pin_low_a: assert property ( // R9
    state_reg.pin_en && state_reg.pin_low && state_reg.flag |-> !o_supply_alarm_out_pin
  ) else $error("active-low pin not low while flag set");

  pin_off_a: assert property ( // R10
    !state_reg.pin_en |-> !o_supply_alarm_out_pin
  ) else $error("alarm pin driven while option off");

  irq_gate_a: assert property ( // R11
    !state_reg.irq_en |-> !o_irq
  ) else $error("interrupt raised while disabled");

  stat_read_a: assert property ( // R12
    i_rd && i_addr == `SUPSUP_OFF_STAT |=> o_rdata[`SUPSUP_STAT_FLAG] == $past(state_reg.flag)
  ) else $error("status read lost the flag");

  flag_clear_a: assert property ( // R13
    state_reg.flag && clr_flag && !below_q |=> !state_reg.flag && !o_irq
  ) else $error("clear did not drop flag and request");

  flag_sticky_a: assert property ( // R15
    state_reg.flag && !clr_flag |=> state_reg.flag
  ) else $error("flag dropped without software clear");

  trip_set_a: assert property ( // R15
    state_reg.en && below_q |=> state_reg.flag
  ) else $error("qualified trip did not set flag");
endmodule // supsup_ctrl

// [common/supsup_defines.svh]
// offsets, fields, resets and timing counts of the supply supervisor control
`ifndef SUPSUP_DEFINES_SVH
`define SUPSUP_DEFINES_SVH
// ====================================================
// register offsets (byte addresses)
`define SUPSUP_OFF_CTRL 8'h00
`define SUPSUP_OFF_TRIP 8'h04
`define SUPSUP_OFF_STAT 8'h08
`define SUPSUP_OFF_MASK 8'h0C
// ====================================================
// control register fields
`define SUPSUP_CTRL_EN 0
`define SUPSUP_CTRL_MON 1
`define SUPSUP_CTRL_FORCED 2
`define SUPSUP_CTRL_FULLPERF 3
`define SUPSUP_CTRL_PINEN 4
`define SUPSUP_CTRL_PINLOW 5
// status / mask fields
`define SUPSUP_STAT_FLAG 0
`define SUPSUP_STAT_BELOW 1
`define SUPSUP_STAT_LINEAR 2
`define SUPSUP_MASK_IE 0
// trip code field
`define SUPSUP_TRIP_MSB 2
// ====================================================
// reset values
`define SUPSUP_RST_CTRL 6'h01
`define SUPSUP_RST_TRIP 3'h0
`define SUPSUP_RST_IE 1'b0
// ====================================================
// timing: comparator qualification, least time
`define SUPSUP_CLK_PERIOD_NS 100
`define SUPSUP_QUAL_TIME_NS 200
`define SUPSUP_QUAL_CYCLES \
  ((`SUPSUP_QUAL_TIME_NS + `SUPSUP_CLK_PERIOD_NS - 1) / `SUPSUP_CLK_PERIOD_NS)
`endif

// [common/supsup_pkg.sv]
// types of the supply supervisor control
package supsup_pkg;
  typedef struct packed {
    logic en;
    logic mon;
    logic forced;
    logic full_perf;
    logic pin_en;
    logic pin_low;
    logic [2:0] trip;
    logic flag;
    logic irq_en;
    logic reset_req;
    logic linear;
    logic pin;
    logic [31:0] rdata;
  } supsup_state_s;

  typedef struct packed {
    logic level;
    logic [7:0] cnt;
  } supsup_qual_s;
endpackage

// [core/supsup_qualify.sv]
// qualifier for the supply comparator level
`timescale 1ns/1ps
`include "supsup_defines.svh"
module supsup_qualify #(
  parameter int QUAL = `SUPSUP_QUAL_CYCLES
) (
  input wire logic i_core_clk, // clock
  input wire logic i_reset, // sync reset, high
  input wire logic i_enable, // supervisor on
  input wire logic i_raw, // comparator says below
  output logic o_level // qualified below level
);
  supsup_pkg::supsup_qual_s state_reg;
  supsup_pkg::supsup_qual_s state_next;

  // ====================================================
  // a change is taken only after QUAL equal samples
  always_comb begin
    state_next = state_reg;
    if (!i_enable) begin
      // off: nothing can be reported
      state_next.level = 1'b0; // R1
      state_next.cnt = 8'h00;
    end else if (i_raw == state_reg.level) begin
      state_next.cnt = 8'h00;
    end else if (state_reg.cnt == 8'(QUAL - 1)) begin
      state_next.level = i_raw;
      state_next.cnt = 8'h00;
    end else begin
      state_next.cnt = state_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_level = state_reg.level;
endmodule // supsup_qualify

// [dv/ssc_supply_model.sv]
// behavioural supply comparator and regulator sense at the far side
`timescale 1ns/1ps
module ssc_supply_model #(
  parameter logic [3:0] DCDC_MIN = 4'h2 // switching minimum, in trip-code steps
) (
  input wire logic i_core_clk, // clock
  input wire logic [3:0] i_supply, // supply level, trip-code steps
  input wire logic i_sup_enable, // comparator power
  input wire logic [2:0] i_trip_code, // selected trip level
  output logic o_below_trip = 1'b0, // supply at or below trip
  output logic o_below_dcdc_min = 1'b0 // supply below switching minimum
);
  // ====
  // comparator
  // output lags the supply by one clock, as a real comparator never answers at once
  always_ff @(posedge i_core_clk) begin
    o_below_trip <= i_sup_enable && (i_supply <= {1'b0, i_trip_code});
    o_below_dcdc_min <= i_supply < DCDC_MIN;
  end
endmodule // ssc_supply_model

// [dv/tb_supply_supervisor_control.sv]
// self-checking bench of the supply supervisor control
`timescale 1ns/1ps
`include "supsup_defines.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_supply_supervisor_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] supply = 4'hF;
  logic [31:0] rdata;
  logic below, dmin, sup_en, fperf, rreq, lin, pin, irq;
  logic [2:0] trip;
  logic [31:0] d;
  int failures = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  supsup_ctrl u_dut (.i_core_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_below_trip(below), .i_below_dcdc_min(dmin), .o_sup_enable(sup_en),
    .o_trip_code(trip), .o_full_perf(fperf), .o_reset_req(rreq), .o_regulator_linear(lin),
    .o_supply_alarm_out_pin(pin), .o_irq(irq));
  ssc_supply_model u_model (.i_core_clk(clk), .i_supply(supply), .i_sup_enable(sup_en),
    .i_trip_code(trip), .o_below_trip(below), .o_below_dcdc_min(dmin));
  // ====
  // bus and timing helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // write then read the same address with no idle cycle between
  task automatic wr_rd_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // supply change reaches the flag after model lag plus qualification
  task automatic set_supply(input logic [3:0] v);
    @(posedge clk);
    supply <= v;
    step(5);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_regs;
    `CHK("enable at reset", 1'b1, sup_en)
    `CHK("irq at reset", 1'b0, irq)
    for (int c = 0; c < 8; c++) begin
      wr_rd_reg(`SUPSUP_OFF_TRIP, {29'h1FFFFFFF, c[2:0]});
      `CHK("trip read", {29'h0, c[2:0]}, d)
      `CHK("trip out", c[2:0], trip)
    end
    wr_reg(`SUPSUP_OFF_CTRL, 32'h9);
    rd_reg(`SUPSUP_OFF_CTRL);
    `CHK("ctrl read", 32'h9, d)
    `CHK("full perf", 1'b1, fperf)
    wr_reg(8'h10, 32'hFF);
    rd_reg(8'h10);
    `CHK("unmapped read", 32'h0, d)
    wr_reg(`SUPSUP_OFF_CTRL, 32'h1);
    `CHK("normal perf", 1'b0, fperf)
    wr_reg(`SUPSUP_OFF_TRIP, 32'h3);
  endtask
  task automatic t_supervise;
    wr_reg(`SUPSUP_OFF_MASK, 32'h1);
    wr_reg(`SUPSUP_OFF_CTRL, 32'h11);
    `CHK("pin idle high pol", 1'b0, pin)
    set_supply(4'h1);
    rd_reg(`SUPSUP_OFF_STAT);
    `CHK("flag set", 1'b1, d[0])
    `CHK("stat word", 32'h7, d)
    `CHK("reset req", 1'b1, rreq)
    `CHK("pin high", 1'b1, pin)
    `CHK("irq up", 1'b1, irq)
    `CHK("linear fallback", 1'b1, lin)
    set_supply(4'hF);
    `CHK("reset req gone", 1'b0, rreq)
    `CHK("flag sticky", 1'b1, irq)
    wr_reg(`SUPSUP_OFF_STAT, 32'h1);
    step(1);
    `CHK("irq cleared", 1'b0, irq)
    `CHK("pin cleared", 1'b0, pin)
  endtask
  task automatic t_monitor;
    wr_reg(`SUPSUP_OFF_MASK, 32'h0);
    wr_reg(`SUPSUP_OFF_CTRL, 32'h37);
    `CHK("pin idle low pol", 1'b1, pin)
    set_supply(4'h1);
    rd_reg(`SUPSUP_OFF_STAT);
    `CHK("flag monitor", 1'b1, d[0])
    `CHK("no reset monitor", 1'b0, rreq)
    `CHK("pin low", 1'b0, pin)
    `CHK("irq masked", 1'b0, irq)
    `CHK("forced switching", 1'b0, lin)
    set_supply(4'hF);
    wr_reg(`SUPSUP_OFF_MASK, 32'h1);
    `CHK("irq unmasked", 1'b1, irq)
    wr_reg(`SUPSUP_OFF_STAT, 32'h1);
    step(1);
    `CHK("irq clear", 1'b0, irq)
  endtask
  task automatic t_pin_off;
    wr_reg(`SUPSUP_OFF_CTRL, 32'h1);
    set_supply(4'h1);
    `CHK("pin ignores flag", 1'b0, pin)
    `CHK("flag via irq", 1'b1, irq)
    wr_reg(`SUPSUP_OFF_STAT, 32'h1);
    `CHK("set beats clear", 1'b1, irq)
    set_supply(4'hF);
    wr_reg(`SUPSUP_OFF_STAT, 32'h1);
    wr_reg(`SUPSUP_OFF_CTRL, 32'h0);
    `CHK("enable off", 1'b0, sup_en)
    set_supply(4'h1);
    rd_reg(`SUPSUP_OFF_STAT);
    `CHK("no flag when off", 1'b0, d[0])
    `CHK("no reset when off", 1'b0, rreq)
    set_supply(4'hF);
  endtask
  // ====
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    step(1);
    t_regs;
    t_supervise;
    t_monitor;
    t_pin_off;
    report_and_stop;
  end
  initial begin
    #(2000 * 100);
    failures++;
    report_and_stop;
  end
endmodule // tb_supply_supervisor_control
